// ---- pcx_pkg.sv ----
package pcx_pkg;

   localparam int NUM_PORTS = 4;
   localparam int NUM_PINS = 32;
   localparam int NUM_XBAR_PINS = 24;
   localparam int NUM_SIGS = 24;

   localparam logic [7:0] ADDR_SELECT_A = 8'hE1;
   localparam logic [7:0] ADDR_SELECT_B = 8'hE2;
   localparam logic [7:0] ADDR_SELECT_C = 8'hE3;
   localparam logic [7:0] ADDR_PORT [NUM_PORTS] = '{8'h80, 8'h90, 8'hA0, 8'hB0};
   localparam logic [7:0] ADDR_DRIVE_CFG [NUM_PORTS] =
      '{8'hA4, 8'hA5, 8'hA6, 8'hA7};

   localparam logic [7:0] RST_SELECT = 8'h00;
   localparam logic [31:0] RST_PORT_LATCH = 32'hFFFFFFFF;
   localparam logic [31:0] RST_DRIVE_CFG = 32'h00000000;
   localparam logic [31:0] RST_PIN_OUT = 32'hFFFFFFFF;
   localparam logic [31:0] RST_PIN_OE = 32'h00000000;
   localparam logic [31:0] RST_PIN_PULLUP = 32'hFFFFFFFF;

   localparam int BIT_TWOWIRE_EN = 0;
   localparam int BIT_SYNC_EN = 1;
   localparam int BIT_ASYNC_EN = 2;
   localparam int PCA_COUNT_LSB = 3;
   localparam int BIT_PCA_CNT_IN_EN = 6;
   localparam int BIT_COMP_A_EN = 7;
   localparam int BIT_ADC_TRIG_EN = 0;
   localparam int BIT_CROSSBAR_EN = 6;
   localparam int BIT_PULLUP_DIS = 7;
   localparam logic [7:0] SELECT_C_MASK = 8'hC1;
   localparam logic [2:0] PCA_MAX_CHANNELS = 3'h5;

   // Signal slot indices in priority order, lowest index wins a pin first.
   localparam int SIG_SDA = 0;
   localparam int SIG_SCL = 1;
   localparam int SIG_RX = 6;

   typedef struct packed {
      logic rd;
      logic wr;
      logic rmw;
      logic bit_wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
      logic bit_val;
   } pcx_sfr_req_t;

   typedef struct packed {
      logic twowire_sda;
      logic twowire_scl;
      logic [3:0] spi_val;
      logic [3:0] spi_oe;
      logic uart_tx;
      logic uart_rx_out;
      logic uart_mode0;
      logic [4:0] pca_channel_io;
      logic [4:0] pca_channel_oe;
      logic comparator_a_out;
      logic comparator_b_out;
      logic system_clock_out;
   } pcx_periph_out_t;

   typedef struct packed {
      logic twowire_sda;
      logic twowire_scl;
      logic [3:0] spi_val;
      logic uart_rx;
      logic [4:0] pca_channel_io;
      logic pca_count_in;
      logic timer0_in;
      logic ext_irq_a_n;
      logic timer1_in;
      logic ext_irq_b_n;
      logic timer2_in;
      logic timer2_ext_in;
      logic adc_trigger_in;
   } pcx_periph_in_t;

endpackage

// ---- pcx_port_io.sv ----
`timescale 1ns/10ps
// Operation
// - Crossbar enable clear keeps all pins as inputs, selections ignored.
// - Each pin drives open-drain or push-pull from its own config bit.
// - Two-wire data, clock and mode-0 receive pins are always open-drain.
// - Pull-up disable clear enables weak pull-ups on open-drain pins only.
// - Weak pull-up is off while an open-drain pin drives low.
// - Selected signals take pins in priority order; unselected yield slots.
// - Only first three ports are crossbar pins; fourth stays port I/O.
// - Select A bits 5:3 route zero to five counter channels; 110/111 reserved.
// - Select A bit 0 routes two-wire data to pin 0, clock pin 1.
// - Select A bit 1 routes the four sync serial signals as a group.
// - Select A bit 2 routes async receive and transmit together.
// - Select A bit 7 routes comparator A, bit 6 counter input.
// - Select B bits route sysclock, timer and interrupt inputs, comparator B.
// - Select C bit 0 routes the converter trigger input.
// - Select C bits 5:1 read zero and ignore writes.
// - Four byte-wide ports with byte and single-bit register access.
// - Port writes are latched and hold pin output data until rewritten.
// - Plain port reads return actual pin levels, routed or not.
// - Read-modify-write reads return the latch, not the pins.
// - Crossbar fills pins LSB to MSB, port zero first.
// - Leftover pins stay port I/O, contiguous after the last assigned.
// - Two-wire group has top priority, lowest two pins of port zero.
module pcx_port_io
   import pcx_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire pcx_sfr_req_t i_sfr_req,
   output logic [7:0] o_sfr_rdata,
   input wire pcx_periph_out_t i_periph,
   output pcx_periph_in_t o_periph,
   input wire logic [NUM_PINS-1:0] i_pin_in,
   output logic [NUM_PINS-1:0] o_pin_out,
   output logic [NUM_PINS-1:0] o_pin_oe,
   output logic [NUM_PINS-1:0] o_pin_pullup
);

   logic [7:0] crossbar_select_a;
   logic [7:0] crossbar_select_b;
   logic [7:0] crossbar_select_c;
   logic [NUM_PINS-1:0] port_latch;
   logic [NUM_PINS-1:0] pin_drive_config;
   logic crossbar_enable_bit;
   logic pullup_disable_bit;
   logic [2:0] pca_channel_route_count;
   logic [4:0] pca_mask;
   logic [NUM_SIGS-1:0] sig_sel;
   logic [NUM_SIGS-1:0] sig_out;
   logic [NUM_SIGS-1:0] sig_oe;
   logic [NUM_SIGS-1:0] sig_od;
   logic [NUM_SIGS-1:0] sig_in;
   logic [NUM_XBAR_PINS-1:0] pin_used;
   logic [4:0] pin_sig [NUM_XBAR_PINS];
   logic [NUM_PINS-1:0] next_pin_out;
   logic [NUM_PINS-1:0] next_pin_oe;
   logic [NUM_PINS-1:0] next_pin_pullup;
   logic [7:0] next_rdata;

   assign crossbar_enable_bit = crossbar_select_c[BIT_CROSSBAR_EN];
   assign pullup_disable_bit = crossbar_select_c[BIT_PULLUP_DIS];
   assign pca_channel_route_count = crossbar_select_a[PCA_COUNT_LSB +: 3];

   // Selection and crossbar configuration registers.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         crossbar_select_a <= RST_SELECT;
         crossbar_select_b <= RST_SELECT;
         crossbar_select_c <= RST_SELECT;
      end else if (i_sfr_req.wr) begin
         if (i_sfr_req.addr == ADDR_SELECT_A) begin
            crossbar_select_a <= i_sfr_req.wdata;
         end
         if (i_sfr_req.addr == ADDR_SELECT_B) begin
            crossbar_select_b <= i_sfr_req.wdata;
         end
         if (i_sfr_req.addr == ADDR_SELECT_C) begin
            crossbar_select_c <= i_sfr_req.wdata & SELECT_C_MASK;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         port_latch <= RST_PORT_LATCH;
         pin_drive_config <= RST_DRIVE_CFG;
      end else begin
         for (int n = 0; n < NUM_PORTS; n++) begin
            if (i_sfr_req.wr && i_sfr_req.addr == ADDR_PORT[n]) begin
               port_latch[n*8 +: 8] <= i_sfr_req.wdata;
            end else if (i_sfr_req.bit_wr && i_sfr_req.addr == ADDR_PORT[n]) begin
               port_latch[n*8 + int'(i_sfr_req.bit_sel)] <= i_sfr_req.bit_val;
            end
            if (i_sfr_req.wr && i_sfr_req.addr == ADDR_DRIVE_CFG[n]) begin
               pin_drive_config[n*8 +: 8] <= i_sfr_req.wdata;
            end
         end
      end
   end

   // Read data is registered, so it appears one cycle after the read strobe.
   always_comb begin
      next_rdata = 8'h00;
      for (int n = 0; n < NUM_PORTS; n++) begin
         if (i_sfr_req.addr == ADDR_PORT[n]) begin
            next_rdata = i_sfr_req.rmw ? port_latch[n*8 +: 8]
                                       : i_pin_in[n*8 +: 8];
         end
         if (i_sfr_req.addr == ADDR_DRIVE_CFG[n]) begin
            next_rdata = pin_drive_config[n*8 +: 8];
         end
      end
      case (i_sfr_req.addr)
         ADDR_SELECT_A: next_rdata = crossbar_select_a;
         ADDR_SELECT_B: next_rdata = crossbar_select_b;
         ADDR_SELECT_C: next_rdata = crossbar_select_c;
         default: ;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_req.rd) begin
         o_sfr_rdata <= next_rdata;
      end
   end

   // Channel count; reserved codes route no channel.
   always_comb begin
      for (int j = 0; j < 5; j++) begin
         pca_mask[j] = (pca_channel_route_count > 3'(j)) &&
                       (pca_channel_route_count <= PCA_MAX_CHANNELS);
      end
   end

   // Slot order from bit 0 upward is the priority order.
   assign sig_sel = {crossbar_select_c[BIT_ADC_TRIG_EN],
                     crossbar_select_b[7],
                     crossbar_select_b[0],
                     crossbar_select_b[6],
                     crossbar_select_b[5],
                     crossbar_select_b[4],
                     crossbar_select_b[3],
                     crossbar_select_b[2],
                     crossbar_select_b[1],
                     crossbar_select_a[BIT_COMP_A_EN],
                     crossbar_select_a[BIT_PCA_CNT_IN_EN],
                     pca_mask,
                     {2{crossbar_select_a[BIT_ASYNC_EN]}},
                     {4{crossbar_select_a[BIT_SYNC_EN]}},
                     {2{crossbar_select_a[BIT_TWOWIRE_EN]}}};

   assign sig_out = {1'b1, i_periph.system_clock_out,
                     i_periph.comparator_b_out, 6'h3F,
                     i_periph.comparator_a_out, 1'b1,
                     i_periph.pca_channel_io, i_periph.uart_tx,
                     i_periph.uart_rx_out, i_periph.spi_val,
                     i_periph.twowire_scl, i_periph.twowire_sda};
   assign sig_oe = {1'b0, 2'h3, 6'h00, 1'b1, 1'b0,
                    i_periph.pca_channel_oe, 1'b1, i_periph.uart_mode0,
                    i_periph.spi_oe, 2'h3};
   assign sig_od = {17'h00000, i_periph.uart_mode0, 4'h0, 2'h3};

   // Pack selected slots onto pins, dropping overflow.
   always_comb begin
      logic [5:0] idx;
      idx = 6'h00;
      pin_used = '0;
      for (int p = 0; p < NUM_XBAR_PINS; p++) begin
         pin_sig[p] = 5'h00;
      end
      for (int k = 0; k < NUM_SIGS; k++) begin
         if (sig_sel[k]) begin
            if (idx < 6'(NUM_XBAR_PINS)) begin
               pin_used[idx[4:0]] = 1'b1;
               pin_sig[idx[4:0]] = 5'(k);
            end
            idx = idx + 6'h01;
         end
      end
   end

   // Per-pin driver, enable and weak pull-up.
   always_comb begin
      logic pp;
      logic [4:0] k;
      pp = 1'b0;
      k = 5'h00;
      for (int p = 0; p < NUM_PINS; p++) begin
         pp = pin_drive_config[p];
         if (!crossbar_enable_bit) begin
            next_pin_out[p] = 1'b1;
            next_pin_oe[p] = 1'b0;
         end else if (p < NUM_XBAR_PINS && pin_used[p]) begin
            k = pin_sig[p];
            pp = pin_drive_config[p] & ~sig_od[k];
            next_pin_out[p] = sig_oe[k] ? sig_out[k] : 1'b1;
            next_pin_oe[p] = sig_oe[k] & (pp | ~sig_out[k]);
         end else begin
            next_pin_out[p] = port_latch[p];
            next_pin_oe[p] = pp | ~port_latch[p];
         end
         next_pin_pullup[p] = ~pullup_disable_bit & ~pp &
                              ~(next_pin_oe[p] & ~next_pin_out[p]);
      end
   end

   // Unrouted peripheral inputs idle high so they never see a false edge.
   always_comb begin
      sig_in = '1;
      for (int p = 0; p < NUM_XBAR_PINS; p++) begin
         if (crossbar_enable_bit && pin_used[p]) begin
            sig_in[pin_sig[p]] = i_pin_in[p];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pin_out <= RST_PIN_OUT;
         o_pin_oe <= RST_PIN_OE;
         o_pin_pullup <= RST_PIN_PULLUP;
      end else begin
         o_pin_out <= next_pin_out;
         o_pin_oe <= next_pin_oe;
         o_pin_pullup <= next_pin_pullup;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_periph <= '1;
      end else begin
         o_periph <= {sig_in[0], sig_in[1], sig_in[5:2], sig_in[6],
                      sig_in[12:8], sig_in[13], sig_in[15], sig_in[16],
                      sig_in[17], sig_in[18], sig_in[19], sig_in[20],
                      sig_in[23]};
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   a_xbar_off_inputs: assert property (
      !crossbar_enable_bit |=> o_pin_oe == '0)
      else $error("Pins driven while crossbar disabled");
   a_twowire_pin_zero: assert property (
      crossbar_enable_bit && crossbar_select_a[0] |=>
      o_pin_out[0] == $past(i_periph.twowire_sda) &&
      o_pin_oe[0] == !$past(i_periph.twowire_sda) &&
      o_pin_oe[1] == !$past(i_periph.twowire_scl))
      else $error("Two-wire signals not on pins 0 and 1");
   a_twowire_od_force: assert property (
      crossbar_enable_bit && crossbar_select_a[0] &&
      i_periph.twowire_sda |=> !o_pin_oe[0])
      else $error("Two-wire data pin driven high");
   a_pullup_low_off: assert property (
      (o_pin_pullup & o_pin_oe & ~o_pin_out) == '0)
      else $error("Pull-up on while driving low");
   a_pullup_disable_all: assert property (
      pullup_disable_bit |=> o_pin_pullup == '0)
      else $error("Pull-up active while disabled");
   a_push_pull_plain: assert property (
      crossbar_enable_bit && crossbar_select_a == 8'h00 &&
      crossbar_select_b == 8'h00 && !crossbar_select_c[BIT_ADC_TRIG_EN] &&
      pin_drive_config[7:0] == 8'hFF
      |=> o_pin_oe[7:0] == 8'hFF)
      else $error("Push-pull port pins not driven");
   a_port3_plain: assert property (
      crossbar_enable_bit |=> o_pin_out[31:24] == $past(port_latch[31:24]))
      else $error("Fourth port not following its latch");
   a_latch_write: assert property (
      i_sfr_req.wr && i_sfr_req.addr == ADDR_PORT[0] ##1
      !(i_sfr_req.wr || i_sfr_req.bit_wr) |->
      port_latch[7:0] == $past(i_sfr_req.wdata))
      else $error("Port latch lost write");
   a_pin_read: assert property (
      i_sfr_req.rd && !i_sfr_req.rmw && i_sfr_req.addr == ADDR_PORT[1]
      |=> o_sfr_rdata == $past(i_pin_in[15:8]))
      else $error("Port read did not return pins");
   a_rmw_read: assert property (
      i_sfr_req.rd && i_sfr_req.rmw && i_sfr_req.addr == ADDR_PORT[2]
      |=> o_sfr_rdata == $past(port_latch[23:16]))
      else $error("Read-modify-write did not return latch");
   a_unused_zero: assert property (
      crossbar_select_c[5:1] == 5'h00)
      else $error("Unused select bits set");

   c_twowire_on: cover property (crossbar_enable_bit && crossbar_select_a[0]);
   c_overflow: cover property (crossbar_enable_bit && $countones(sig_sel) > 24);
   c_rmw_read: cover property (i_sfr_req.rd && i_sfr_req.rmw);

endmodule

// ---- pcx_port_io_tb.sv ----
`timescale 1ns/10ps
module pcx_port_io_tb;
   import pcx_pkg::*;

   typedef struct packed {
      logic [7:0] sel_a;
      logic [7:0] sel_b;
      logic [7:0] sel_c;
      logic [31:0] exp_oe;
      logic [31:0] exp_out;
   } pcx_row_t;

   // Unrouted pins are latched low and push-pull, so every one of them drives while the crossbar is enabled.
   localparam int NUM_ROWS = 14;
   localparam pcx_row_t ROWS [NUM_ROWS] = '{
      '{8'h01, 8'h00, 8'h40, 32'hFFFFFFFD, 32'h00000000},
      '{8'h02, 8'h00, 8'h40, 32'hFFFFFFFF, 32'h0000000A},
      '{8'h28, 8'h00, 8'h40, 32'hFFFFFFFF, 32'h00000015},
      '{8'h30, 8'h00, 8'h40, 32'hFFFFFFFF, 32'h00000000},
      '{8'h38, 8'h00, 8'h40, 32'hFFFFFFFF, 32'h00000000},
      '{8'hC0, 8'h00, 8'h40, 32'hFFFFFFFE, 32'h00000002},
      '{8'h00, 8'h81, 8'h40, 32'hFFFFFFFF, 32'h00000003},
      '{8'h00, 8'h7E, 8'h40, 32'hFFFFFFC0, 32'h00000000},
      '{8'h00, 8'h00, 8'h41, 32'hFFFFFFFE, 32'h00000000},
      '{8'h01, 8'hFF, 8'h01, 32'h00000000, 32'h00000000},
      '{8'h04, 8'h00, 8'h40, 32'hFFFFFFFE, 32'h00000002},
      '{8'h07, 8'h00, 8'h40, 32'hFFFFFFBD, 32'h000000A8},
      '{8'h08, 8'h01, 8'h41, 32'hFFFFFFFB, 32'h00000003},
      '{8'hEF, 8'hFF, 8'h41, 32'hFF605FBD, 32'h006055A8}
   };

   logic i_clk_sys;
   logic i_arst_n;
   pcx_sfr_req_t req;
   logic [7:0] o_sfr_rdata;
   pcx_periph_out_t periph;
   pcx_periph_in_t o_periph;
   logic [31:0] pin_in;
   logic [31:0] o_pin_out;
   logic [31:0] o_pin_oe;
   logic [31:0] o_pin_pullup;
   int num_errors = 0;
   int compares = 0;

   pcx_port_io i_pcx_port_io (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_sfr_req(req),
      .o_sfr_rdata(o_sfr_rdata),
      .i_periph(periph),
      .o_periph(o_periph),
      .i_pin_in(pin_in),
      .o_pin_out(o_pin_out),
      .o_pin_oe(o_pin_oe),
      .o_pin_pullup(o_pin_pullup)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   task automatic end_sim();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge i_clk_sys);
      req.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic m,
                         input logic [7:0] exp);
      @(posedge i_clk_sys);
      req.rd <= 1'b1;
      req.addr <= a;
      req.rmw <= m;
      @(posedge i_clk_sys);
      req.rd <= 1'b0;
      @(posedge i_clk_sys);
      #1;
      chk({24'h0, o_sfr_rdata}, {24'h0, exp});
   endtask

   // Pins follow the registers one edge later; three leaves margin.
   task automatic settle();
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic set_sel(input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
      wr(ADDR_SELECT_A, a);
      wr(ADDR_SELECT_B, b);
      wr(ADDR_SELECT_C, c);
      settle();
   endtask

   initial begin
      repeat (5000) @(posedge i_clk_sys);
      num_errors++;
      end_sim();
   end

   initial begin
      i_arst_n = 1'b0;
      req = '0;
      pin_in = 32'hFFFFFFFF;
      periph = '0;
      periph.twowire_scl = 1'b1;
      periph.spi_val = 4'hA;
      periph.spi_oe = 4'hF;
      periph.uart_tx = 1'b1;
      periph.uart_rx_out = 1'b1;
      periph.pca_channel_io = 5'h15;
      periph.pca_channel_oe = 5'h1F;
      periph.comparator_a_out = 1'b1;
      periph.comparator_b_out = 1'b1;
      periph.system_clock_out = 1'b1;
      repeat (5) @(posedge i_clk_sys);
      #1;
      chk(o_pin_oe, RST_PIN_OE);
      chk(o_pin_pullup, RST_PIN_PULLUP);
      chk(o_pin_out, RST_PIN_OUT);
      @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      rd_chk(ADDR_SELECT_A, 1'b0, 8'h00);
      rd_chk(ADDR_SELECT_B, 1'b0, 8'h00);
      rd_chk(ADDR_SELECT_C, 1'b0, 8'h00);
      rd_chk(ADDR_DRIVE_CFG[0], 1'b0, 8'h00);
      rd_chk(ADDR_PORT[0], 1'b1, 8'hFF);
      for (int p = 0; p < NUM_PORTS; p++) begin
         wr(ADDR_PORT[p], 8'h00);
         wr(ADDR_DRIVE_CFG[p], 8'hFF);
      end
      for (int i = 0; i < NUM_ROWS; i++) begin
         set_sel(ROWS[i].sel_a, ROWS[i].sel_b, ROWS[i].sel_c);
         chk(o_pin_oe, ROWS[i].exp_oe);
         chk(o_pin_out & o_pin_oe, ROWS[i].exp_out);
      end
      wr(ADDR_SELECT_C, 8'hFF);
      rd_chk(ADDR_SELECT_C, 1'b0, 8'hC1);
      rd_chk(ADDR_SELECT_A, 1'b0, 8'hEF);
      rd_chk(8'h55, 1'b0, 8'h00);
      pin_in <= 32'h3C5A96A5;
      rd_chk(ADDR_PORT[0], 1'b0, 8'hA5);
      rd_chk(ADDR_PORT[0], 1'b1, 8'h00);
      @(posedge i_clk_sys);
      req.bit_wr <= 1'b1;
      req.addr <= ADDR_PORT[1];
      req.bit_sel <= 3'h3;
      req.bit_val <= 1'b1;
      @(posedge i_clk_sys);
      req.bit_wr <= 1'b0;
      rd_chk(ADDR_PORT[1], 1'b1, 8'h08);
      rd_chk(ADDR_PORT[1], 1'b0, 8'h96);
      rd_chk(ADDR_PORT[2], 1'b1, 8'h00);
      // Mode-0 receive drives low but only floats high, even on push-pull.
      periph.uart_mode0 <= 1'b1;
      periph.uart_rx_out <= 1'b0;
      set_sel(8'h04, 8'h00, 8'h40);
      chk(o_pin_oe & 32'h3, 32'h3);
      periph.uart_rx_out <= 1'b1;
      settle();
      chk(o_pin_oe & 32'h3, 32'h2);
      periph.uart_mode0 <= 1'b0;
      wr(ADDR_DRIVE_CFG[0], 8'h00);
      wr(ADDR_PORT[0], 8'h0F);
      set_sel(8'h02, 8'h00, 8'h40);
      chk(o_pin_oe, 32'hFFFFFFF5);
      chk(o_pin_pullup, 32'h0000000A);
      wr(ADDR_SELECT_C, 8'hC0);
      settle();
      chk(o_pin_pullup, 32'h00000000);
      pin_in <= 32'h3C5A96A4;
      set_sel(8'h40, 8'h00, 8'h40);
      chk({31'h0, o_periph.pca_count_in}, 32'h0);
      chk({31'h0, o_periph.timer0_in}, 32'h1);
      pin_in <= 32'h3C5A96A2;
      set_sel(8'h01, 8'h02, 8'h40);
      chk({31'h0, o_periph.twowire_sda}, 32'h0);
      chk({31'h0, o_periph.twowire_scl}, 32'h1);
      chk({31'h0, o_periph.timer0_in}, 32'h0);
      chk({31'h0, o_periph.timer2_ext_in}, 32'h1);
      end_sim();
   end
endmodule
